// >>> core/kel_status_port.sv
// Purpose: Emulation status register and system control port of the keyboard emulation logic
// Assumes: One clock, synchronous reset; I/O and memory strobes are one-cycle pulses
// Notes: I/O read data is combinational from the stored bits; memory access has no side effects
`timescale 1ns/100ps
`default_nettype none
module kes_status_port (
  input wire logic clk_i,
  input wire logic srst_i,
  // Legacy I/O port access
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic [15:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  output logic io_claim_o,
  output logic io_to_lpc_o,
  // Memory-space register access
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic [11:0] mem_addr_i,
  input wire logic [31:0] mem_wdata_i,
  output logic [31:0] mem_rdata_o,
  // Control bits held elsewhere
  input wire logic emulation_on_i,
  input wire logic legacy_irq_enable_i,
  input wire logic char_waiting_event_enable_i,
  input wire logic control_port_enable_i,
  input wire logic smi_a20_enable_i,
  input wire logic smi_reset_enable_i,
  input wire logic keyboard_not_locked_i,
  // Outputs
  output logic keyboard_irq_line_o,
  output logic mouse_irq_line_o,
  output logic emulation_event_o,
  output logic sys_mgmt_interrupt_o,
  output logic soft_reset_request_o,
  output logic addr20_gate_o,
  output logic addr20_sequence_active_o
);
  import kes_pkg::*;

  logic [7:0] sts_r, sts_nxt;
  logic a20_gate_r, a20_gate_nxt;
  logic a20_seq_r, a20_seq_nxt;
  logic smi_r, smi_nxt;
  logic srr_r, srr_nxt;
  logic [31:0] mem_rdata_r;
  logic kbd_in_r1, kbd_in_r2;

  // Access decode
  wire emu_io = emulation_on_i;
  wire io_dat = (io_addr_i == KES_IO_DATA) && emu_io;
  wire io_cmd = (io_addr_i == KES_IO_CMD) && emu_io;
  wire io_prt = (io_addr_i == KES_IO_PORT);
  wire wr_dat = io_wr_i && io_dat;
  wire wr_cmd = io_wr_i && io_cmd;
  wire rd_dat = io_rd_i && io_dat;
  wire prt_hit = io_prt && control_port_enable_i;
  wire wr_prt = io_wr_i && prt_hit;
  wire mem_sel = (mem_addr_i == KES_STS_OFF);
  wire mem_wr = mem_wr_i && mem_sel;
  wire a20_data_wr = wr_dat && a20_seq_r;
  wire [7:0] sts_view = {sts_r[7:5], kbd_in_r2, sts_r[3:0]};

  // Keyboard inhibit switch comes from a pin: two-flop synchroniser
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      kbd_in_r1 <= 1'b0;
      kbd_in_r2 <= 1'b0;
    end else begin
      kbd_in_r1 <= keyboard_not_locked_i;
      kbd_in_r2 <= kbd_in_r1;
    end
  end

  // Status next state; memory write has lowest priority against hardware sets
  always_comb begin
    sts_nxt = sts_r;
    if (mem_wr) begin
      sts_nxt = mem_wdata_i[7:0];
    end
    if (wr_dat) begin
      sts_nxt[KES_B_CMD] = 1'b0;
    end
    if (wr_cmd) begin
      sts_nxt[KES_B_CMD] = 1'b1;
    end
    if ((wr_dat && !a20_seq_r) || wr_cmd) begin
      sts_nxt[KES_B_INF] = 1'b1;
    end
    if (rd_dat && !(mem_wr && mem_wdata_i[KES_B_OUTF])) begin
      sts_nxt[KES_B_OUTF] = 1'b0;
    end
    // Bit 4 is never stored; reads show the synchronised switch instead
    sts_nxt[KES_B_INH] = 1'b0;
  end

  // A20 sequence flag and control port
  always_comb begin
    a20_seq_nxt = a20_seq_r;
    if (wr_cmd) begin
      a20_seq_nxt = (io_wdata_i == KES_CMD_A20);
    end
    a20_gate_nxt = a20_gate_r;
    if (wr_prt) begin
      a20_gate_nxt = io_wdata_i[KES_P_A20];
    end
    smi_nxt = (wr_prt && (io_wdata_i[KES_P_A20] != a20_gate_r) && smi_a20_enable_i);
    srr_nxt = wr_prt && io_wdata_i[KES_P_RST] && smi_reset_enable_i;
  end

  // State registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sts_r <= KES_STS_RST;
      a20_gate_r <= KES_PORT_RST[KES_P_A20];
      a20_seq_r <= 1'b0;
      smi_r <= 1'b0;
      srr_r <= 1'b0;
    end else begin
      sts_r <= sts_nxt;
      a20_gate_r <= a20_gate_nxt;
      a20_seq_r <= a20_seq_nxt;
      smi_r <= smi_nxt;
      srr_r <= srr_nxt;
    end
  end

  // Memory read data, registered one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mem_rdata_r <= 32'h0000_0000;
    end else if (mem_rd_i) begin
      mem_rdata_r <= mem_sel ? {24'h00_0000, sts_view} : 32'h0000_0000;
    end
  end

  // I/O read data: status on 064h, port with reset bit reading zero
  assign io_rdata_o = io_cmd ? sts_view :
                      prt_hit ? {6'h00, a20_gate_r, 1'b0} : 8'h00;
  assign io_claim_o = io_cmd || prt_hit;
  assign io_to_lpc_o = io_prt && !control_port_enable_i;
  assign mem_rdata_o = mem_rdata_r;

  // Interrupt outputs
  wire irq_ok = emu_io && legacy_irq_enable_i && sts_r[KES_B_OUTF];
  assign keyboard_irq_line_o = irq_ok && !sts_r[KES_B_AUX];
  assign mouse_irq_line_o = irq_ok && sts_r[KES_B_AUX];
  assign emulation_event_o = emu_io && (sts_r[KES_B_INF] ||
                             (!sts_r[KES_B_OUTF] && char_waiting_event_enable_i));
  assign sys_mgmt_interrupt_o = smi_r;
  assign soft_reset_request_o = srr_r;
  assign addr20_gate_o = a20_gate_r;
  assign addr20_sequence_active_o = a20_seq_r;

  // Checks: flag updates caused by legacy I/O accesses
  property p_cmd_sets;
    @(posedge clk_i) disable iff (srst_i) wr_cmd |=> sts_r[KES_B_CMD] && sts_r[KES_B_INF];
  endproperty
  a_cmd_sets: assert property (p_cmd_sets) else $error("cmd write flags wrong");
  property p_dat_clr;
    @(posedge clk_i) disable iff (srst_i) wr_dat |=> !sts_r[KES_B_CMD];
  endproperty
  a_dat_clr: assert property (p_dat_clr) else $error("data write kept cmd bit");
  property p_a20_seq;
    @(posedge clk_i) disable iff (srst_i) a20_data_wr && !mem_wr |=> $stable(sts_r[KES_B_INF]);
  endproperty
  a_a20_seq: assert property (p_a20_seq) else $error("A20 data set input full");
  property p_outf_clr;
    @(posedge clk_i) disable iff (srst_i) rd_dat && !mem_wr |=> !sts_r[KES_B_OUTF];
  endproperty
  a_outf_clr: assert property (p_outf_clr) else $error("output full not cleared");

  // Checks: bits 7:5 and 2 move, input full clears and output full sets only on a direct write
  property p_par;
    @(posedge clk_i) disable iff (srst_i) !mem_wr |=> $stable(sts_r[7:5]);
  endproperty
  a_par: assert property (p_par) else $error("sw-only bits changed");
  property p_flag;
    @(posedge clk_i) disable iff (srst_i) !mem_wr |=> $stable(sts_r[KES_B_FLAG]);
  endproperty
  a_flag: assert property (p_flag) else $error("software flag changed");
  property p_inf_hold;
    @(posedge clk_i) disable iff (srst_i) sts_r[KES_B_INF] && !mem_wr |=> sts_r[KES_B_INF];
  endproperty
  a_inf_hold: assert property (p_inf_hold) else $error("input full lost");
  property p_outf_hold;
    @(posedge clk_i) disable iff (srst_i) !sts_r[KES_B_OUTF] && !mem_wr |=> !sts_r[KES_B_OUTF];
  endproperty
  a_outf_hold: assert property (p_outf_hold) else $error("output full set by hw");

  // Checks: a lone direct write stores the byte except bit 4 and nothing else
  property p_mem_only;
    @(posedge clk_i) disable iff (srst_i)
      mem_wr && !wr_dat && !wr_cmd && !rd_dat |=> sts_r == ($past(mem_wdata_i[7:0]) & 8'hef);
  endproperty
  a_mem_only: assert property (p_mem_only) else $error("direct write not stored");
  property p_no_side;
    @(posedge clk_i) disable iff (srst_i) mem_wr_i && !io_wr_i |=> !smi_r && !srr_r;
  endproperty
  a_no_side: assert property (p_no_side) else $error("direct write had side effect");
  property p_memrd_hi;
    @(posedge clk_i) disable iff (srst_i) mem_rdata_o[31:8] == 24'h00_0000;
  endproperty
  a_memrd_hi: assert property (p_memrd_hi) else $error("reserved status bits set");

  // Checks: I/O read data and routing
  property p_cmd_rd;
    @(posedge clk_i) disable iff (srst_i) io_cmd |-> io_rdata_o == sts_view;
  endproperty
  a_cmd_rd: assert property (p_cmd_rd) else $error("status read data wrong");
  property p_prt_rd;
    @(posedge clk_i) disable iff (srst_i)
      prt_hit |-> io_rdata_o[7:2] == 6'h00 && !io_rdata_o[0];
  endproperty
  a_prt_rd: assert property (p_prt_rd) else $error("port reserved bits set");
  property p_lpc;
    @(posedge clk_i) disable iff (srst_i) io_to_lpc_o |-> !io_claim_o;
  endproperty
  a_lpc: assert property (p_lpc) else $error("port claimed and forwarded");

  // Checks: sequence flag
  property p_seq;
    @(posedge clk_i) disable iff (srst_i) wr_cmd && io_wdata_i == KES_CMD_A20 |=> a20_seq_r;
  endproperty
  a_seq: assert property (p_seq) else $error("A20 sequence not set");
  property p_seq_clr;
    @(posedge clk_i) disable iff (srst_i) wr_cmd && io_wdata_i != KES_CMD_A20 |=> !a20_seq_r;
  endproperty
  a_seq_clr: assert property (p_seq_clr) else $error("A20 sequence not cleared");

  // Checks: interrupt pulses from the control port
  property p_smi;
    @(posedge clk_i) disable iff (srst_i)
      wr_prt && (io_wdata_i[KES_P_A20] != a20_gate_r) && smi_a20_enable_i |=> smi_r;
  endproperty
  a_smi: assert property (p_smi) else $error("no SMI on gate change");
  property p_smi_src;
    @(posedge clk_i) disable iff (srst_i) sys_mgmt_interrupt_o |-> $past(wr_prt);
  endproperty
  a_smi_src: assert property (p_smi_src) else $error("stray SMI");
  property p_rst;
    @(posedge clk_i) disable iff (srst_i) soft_reset_request_o |-> $past(wr_prt);
  endproperty
  a_rst: assert property (p_rst) else $error("stray soft reset");
  property p_rst_en;
    @(posedge clk_i) disable iff (srst_i) soft_reset_request_o |-> $past(smi_reset_enable_i);
  endproperty
  a_rst_en: assert property (p_rst_en) else $error("soft reset while disabled");

  // Checks: interrupt and event levels
  property p_irq;
    @(posedge clk_i) disable iff (srst_i) !(keyboard_irq_line_o && mouse_irq_line_o);
  endproperty
  a_irq: assert property (p_irq) else $error("both irqs high");
  property p_kbd;
    @(posedge clk_i) disable iff (srst_i)
      emulation_on_i && legacy_irq_enable_i && sts_r[KES_B_OUTF] && !sts_r[KES_B_AUX]
      |-> keyboard_irq_line_o;
  endproperty
  a_kbd: assert property (p_kbd) else $error("keyboard irq missing");
  property p_mouse;
    @(posedge clk_i) disable iff (srst_i)
      emulation_on_i && legacy_irq_enable_i && sts_r[KES_B_OUTF] && sts_r[KES_B_AUX]
      |-> mouse_irq_line_o;
  endproperty
  a_mouse: assert property (p_mouse) else $error("mouse irq missing");
  property p_ev_inf;
    @(posedge clk_i) disable iff (srst_i) emulation_on_i && sts_r[KES_B_INF] |-> emulation_event_o;
  endproperty
  a_ev_inf: assert property (p_ev_inf) else $error("event missing on input full");
  property p_ev_chr;
    @(posedge clk_i) disable iff (srst_i)
      emulation_on_i && !sts_r[KES_B_OUTF] && char_waiting_event_enable_i |-> emulation_event_o;
  endproperty
  a_ev_chr: assert property (p_ev_chr) else $error("event missing on char wait");
  property p_off;
    @(posedge clk_i) disable iff (srst_i)
      !emulation_on_i |-> !keyboard_irq_line_o && !mouse_irq_line_o && !emulation_event_o;
  endproperty
  a_off: assert property (p_off) else $error("activity with emulation off");

  // Main scenarios
  c_cmd: cover property (@(posedge clk_i) wr_cmd);
  c_seq: cover property (@(posedge clk_i) a20_seq_r ##1 a20_data_wr);
  c_smi: cover property (@(posedge clk_i) smi_r);
  c_mouse: cover property (@(posedge clk_i) mouse_irq_line_o);
  c_srr: cover property (@(posedge clk_i) srr_r);
endmodule
`default_nettype wire

// >>> inc/kel_pkg.sv
// Purpose: Shared constants for the keyboard emulation status and control port block
// Assumes: Byte-wide legacy I/O port bus and a 32-bit memory-space register port
// Notes: Offsets and bit positions for the two registers and the decoded I/O ports
package kes_pkg;
  // Memory-space offset of the emulation status register
  localparam logic [11:0] KES_STS_OFF = 12'h10c;
  // Legacy I/O ports
  localparam logic [15:0] KES_IO_DATA = 16'h0060;
  localparam logic [15:0] KES_IO_CMD = 16'h0064;
  localparam logic [15:0] KES_IO_PORT = 16'h0092;
  // Command that opens the address-bit-20 sequence
  localparam logic [7:0] KES_CMD_A20 = 8'hd1;
  // Status bit positions
  localparam int KES_B_OUTF = 0;
  localparam int KES_B_INF = 1;
  localparam int KES_B_FLAG = 2;
  localparam int KES_B_CMD = 3;
  localparam int KES_B_INH = 4;
  localparam int KES_B_AUX = 5;
  localparam int KES_B_TMO = 6;
  localparam int KES_B_PAR = 7;
  // Control port bit positions
  localparam int KES_P_RST = 0;
  localparam int KES_P_A20 = 1;
  // Reset values
  localparam logic [7:0] KES_STS_RST = 8'h00;
  localparam logic [7:0] KES_PORT_RST = 8'h00;
endpackage

// >>> testbench/kel_host_bfm.sv
// Purpose: Host model issuing legacy I/O and memory accesses
// Assumes: Strobes last one clock and change 1 ns after the edge
// Notes: Released address and data lines show the inverse of their last value
`timescale 1ns/100ps
`default_nettype none
module kes_host_bfm (
  input wire logic clk_i,
  input wire logic [7:0] io_rdata_i,
  input wire logic io_claim_i,
  input wire logic io_to_lpc_i,
  output logic io_rd_o,
  output logic io_wr_o,
  output logic [15:0] io_addr_o,
  output logic [7:0] io_wdata_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [11:0] mem_addr_o,
  output logic [31:0] mem_wdata_o
);
  logic [7:0] rd_q;
  logic [1:0] route_q;
  // Bus idle at time zero
  initial begin
    {io_rd_o, io_wr_o, mem_rd_o, mem_wr_o} = 4'h0;
    {io_addr_o, io_wdata_o, mem_addr_o, mem_wdata_o} = '0;
  end
  // One I/O cycle; read data and routing taken while the strobe stands
  task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i) #1;
    {io_rd_o, io_wr_o, io_addr_o, io_wdata_o} = {~wr, wr, a, d};
    #4 rd_q = io_rdata_i;
    route_q = {io_claim_i, io_to_lpc_i};
    @(posedge clk_i) #1;
    {io_rd_o, io_wr_o, io_addr_o, io_wdata_o} = {2'b00, ~a, ~d};
  endtask
  // One memory cycle; read data is registered, valid on return
  task automatic mem(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i) #1;
    {mem_rd_o, mem_wr_o, mem_addr_o, mem_wdata_o} = {~wr, wr, a, d};
    @(posedge clk_i) #1;
    {mem_rd_o, mem_wr_o, mem_addr_o, mem_wdata_o} = {2'b00, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// >>> testbench/test_kel_status_port.sv
// Purpose: Self-checking bench for the status register and control port
// Assumes: Control bits are driven directly as levels
// Notes: Each scenario task drives and judges its own results
`timescale 1ns/100ps
`default_nettype none
module test_kbd_emul_status_and_porta;
  import kes_pkg::*;
  logic clk_i = 1'b0, srst_i = 1'b1, emulation_on_i = 1'b0, legacy_irq_enable_i = 1'b0;
  logic char_waiting_event_enable_i = 1'b0, control_port_enable_i = 1'b1;
  logic smi_a20_enable_i = 1'b1, smi_reset_enable_i = 1'b1, keyboard_not_locked_i = 1'b0;
  logic io_rd_i, io_wr_i, mem_rd_i, mem_wr_i, io_claim_o, io_to_lpc_o;
  logic [15:0] io_addr_i;
  logic [7:0] io_wdata_i, io_rdata_o;
  logic [11:0] mem_addr_i;
  logic [31:0] mem_wdata_i, mem_rdata_o;
  logic keyboard_irq_line_o, mouse_irq_line_o, emulation_event_o, sys_mgmt_interrupt_o;
  logic soft_reset_request_o, addr20_gate_o, addr20_sequence_active_o;
  int err_count = 0, n_compared = 0, cyc = 0;
  kes_status_port u_dut (.clk_i, .srst_i, .io_rd_i, .io_wr_i, .io_addr_i, .io_wdata_i,
    .io_rdata_o, .io_claim_o, .io_to_lpc_o, .mem_rd_i, .mem_wr_i, .mem_addr_i, .mem_wdata_i,
    .mem_rdata_o, .emulation_on_i, .legacy_irq_enable_i, .char_waiting_event_enable_i,
    .control_port_enable_i, .smi_a20_enable_i, .smi_reset_enable_i, .keyboard_not_locked_i,
    .keyboard_irq_line_o, .mouse_irq_line_o, .emulation_event_o, .sys_mgmt_interrupt_o,
    .soft_reset_request_o, .addr20_gate_o, .addr20_sequence_active_o);
  kes_host_bfm u_host (.clk_i, .io_rdata_i(io_rdata_o), .io_claim_i(io_claim_o),
    .io_to_lpc_i(io_to_lpc_o), .io_rd_o(io_rd_i), .io_wr_o(io_wr_i), .io_addr_o(io_addr_i),
    .io_wdata_o(io_wdata_i), .mem_rd_o(mem_rd_i), .mem_wr_o(mem_wr_i),
    .mem_addr_o(mem_addr_i), .mem_wdata_o(mem_wdata_i));
  // Clock and hang limit
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      final_report();
    end
  end
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Status read through memory space
  task automatic sts(input logic [31:0] exp);
    u_host.mem(1'b0, KES_STS_OFF, 32'h0);
    chk(mem_rdata_o, exp);
  endtask
  // Command, data and sequence flag handling
  task automatic t_cmd;
    sts(32'h0);
    {emulation_on_i, keyboard_not_locked_i} = 2'b11;
    u_host.io(1'b1, KES_IO_CMD, KES_CMD_A20);
    chk({addr20_sequence_active_o, emulation_event_o}, 2'b11);
    u_host.io(1'b0, KES_IO_CMD, 8'h00);
    chk(u_host.rd_q, 8'h1a);
    u_host.mem(1'b1, KES_STS_OFF, 32'h0);
    chk({addr20_sequence_active_o, emulation_event_o}, 2'b10);
    u_host.io(1'b1, KES_IO_DATA, 8'h55);
    sts(32'h10);
    u_host.io(1'b1, KES_IO_CMD, 8'h20);
    chk(addr20_sequence_active_o, 1'b0);
    u_host.mem(1'b1, KES_STS_OFF, 32'h0);
    u_host.io(1'b1, KES_IO_DATA, 8'h55);
    sts(32'h12);
    $display("t_cmd done");
  endtask
  // Direct writes, interrupt lines and output-full clearing
  task automatic t_mem;
    legacy_irq_enable_i = 1'b1;
    u_host.mem(1'b1, KES_STS_OFF, 32'hffffffe5);
    sts(32'hf5);
    chk({mouse_irq_line_o, keyboard_irq_line_o, emulation_event_o}, 3'b100);
    u_host.mem(1'b1, KES_STS_OFF, 32'h01);
    chk({mouse_irq_line_o, keyboard_irq_line_o}, 2'b01);
    char_waiting_event_enable_i = 1'b1;
    u_host.io(1'b0, KES_IO_DATA, 8'h00);
    chk({keyboard_irq_line_o, emulation_event_o}, 2'b01);
    sts(32'h10);
    char_waiting_event_enable_i = 1'b0;
    u_host.mem(1'b1, 12'h100, 32'hffffffff);
    u_host.mem(1'b0, 12'h100, 32'h0);
    chk(mem_rdata_o, 32'h0);
    $display("t_mem done");
  endtask
  // Control port gate, soft reset and forwarding
  task automatic t_port;
    u_host.io(1'b1, KES_IO_PORT, 8'hff);
    chk({addr20_gate_o, sys_mgmt_interrupt_o, soft_reset_request_o}, 3'b111);
    u_host.io(1'b0, KES_IO_PORT, 8'h00);
    chk({u_host.route_q, u_host.rd_q}, {2'b10, 8'h02});
    u_host.io(1'b1, KES_IO_PORT, 8'h02);
    chk({sys_mgmt_interrupt_o, soft_reset_request_o}, 2'b00);
    {smi_a20_enable_i, smi_reset_enable_i} = 2'b00;
    u_host.io(1'b1, KES_IO_PORT, 8'h01);
    chk({addr20_gate_o, sys_mgmt_interrupt_o, soft_reset_request_o}, 3'b000);
    control_port_enable_i = 1'b0;
    u_host.io(1'b1, KES_IO_PORT, 8'h02);
    chk({u_host.route_q, addr20_gate_o}, 3'b010);
    $display("t_port done");
  endtask
  // Emulation off: command port write ignored, keyboard interrupt and sequence flag quiet
  task automatic t_off;
    emulation_on_i = 1'b0;
    u_host.mem(1'b1, KES_STS_OFF, 32'h01);
    u_host.io(1'b1, KES_IO_CMD, KES_CMD_A20);
    chk({u_host.route_q, keyboard_irq_line_o, addr20_sequence_active_o}, 4'h0);
    sts(32'h11);
    $display("t_off done");
  endtask
  // Counts and verdict
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Reset, then the scenarios
  initial begin
    repeat (10) @(posedge clk_i);
    #1 srst_i = 1'b0;
    t_cmd();
    t_mem();
    t_port();
    t_off();
    final_report();
  end
endmodule
`default_nettype wire
